// ==== hw/daylight_dimming_pwm_outputs.sv ====
// Dimming output stage: level selection, PWM timing, sync and Wishbone registers.
//
// What this block does
// - All output timing comes from one 16 MHz master time base.
// - Outputs are three PWMs, or analog first channel plus two PWMs, by mode.
// - Each PWM has 12-bit duty resolution and runs at 888 Hz by default.
// - All PWMs share one frequency; their edges never coincide while the level is steady and no sync restart occurs.
// - Primary output spans 0 to 100 percent, analog or pulse.
// - Second and third outputs are always PWM and follow the primary level.
// - A mode strap picks analog primary (mode 0) or pulse primary (mode 1).
// - Level comes from the dimmer input or a network command.
// - Dimmer input is a 10-bit code; lowest means full dimming.
// - PWM periods can align to an external sync signal.
// - With nothing on the sync pin, sync turns off and outputs run free.
// - Sync pin low beyond 100 ms resets; shorter lows are sync only.
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`include "dim_pwm_consts.svh"
module daylight_dimming_pwm_outputs #(
    parameter int PWM_FREQ_HZ = `PWM_FREQ_HZ,
    parameter int LONG_CYCLES = `LONG_PRESS_MS * (`CORE_CLK_HZ / 1000),
    parameter int LOSS_CYCLES = `SYNC_LOSS_MS * (`CORE_CLK_HZ / 1000),
    parameter int PERIOD = (`MASTER_CLK_HZ + PWM_FREQ_HZ / 2) / PWM_FREQ_HZ
) (
    // Clock and reset.
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    // Wishbone classic slave.
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic WB_ACK_O,
    output logic [31:0] WB_DAT_O,
    // Inputs from the pins.
    input wire logic [9:0] DIMMER_LEVEL_INPUT_I,
    input wire logic MODE_STRAP_I,
    input wire logic SYNC_OR_RESET_PIN_I,
    // Outputs to ballasts and drivers.
    output logic PRIMARY_ANALOG_OR_PULSE_PIN_O,
    output logic [11:0] PRIMARY_ANALOG_LEVEL_O,
    output logic SECOND_OUTPUT_ALIAS_O,
    output logic THIRD_OUTPUT_ALIAS_O,
    output logic LONG_PRESS_RESET_O
);
    localparam logic [7:0] TICK_STEP = 8'(`MASTER_CLK_HZ / 1000000);
    localparam logic [7:0] TICK_DEN = 8'(`CORE_CLK_HZ / 1000000);
    localparam int OFS = PERIOD / `PWM_CHANNELS;
    localparam logic [14:0] P15 = 15'(PERIOD);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic src_net;
        logic sync_en;
        logic [9:0] net_level;
        logic strap_done;
        dim_pwm_pkg::out_mode_e mode;
        logic [7:0] acc;
        logic tick;
        dim_pwm_pkg::period_cnt_t cnt;
        dim_pwm_pkg::duty_t level;
        dim_pwm_pkg::period_cnt_t thr;
        dim_pwm_pkg::duty_t analog;
        logic rst_req;
    } main_s;

    logic rst_meta_q;
    logic rst_n;
    main_s st_q;
    main_s st_d;
    logic sync_evt;
    logic sync_present;
    logic long_press;
    logic [2:0] pwm;
    logic [2:0] pwm_en;
    logic [8:0] acc_sum;
    logic wrap;
    logic restart;
    logic [26:0] prod;
    dim_pwm_pkg::period_cnt_t thr_raw;
    dim_pwm_pkg::period_cnt_t thr_fix;
    logic wb_req;

    // The external reset is released through two flops.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // The sync pin filter: sync events, presence and the long-press reset.
    sync_reset_monitor #(
        .LONG_CYCLES(LONG_CYCLES),
        .LOSS_CYCLES(LOSS_CYCLES)
    ) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_n_i(rst_n),
        .pin_i(SYNC_OR_RESET_PIN_I),
        .sync_evt_o(sync_evt),
        .present_o(sync_present),
        .long_press_o(long_press)
    );

    // In analog mode the first comparator is held off; the others always run.
    assign pwm_en = {2'b11, st_q.strap_done && st_q.mode == dim_pwm_pkg::MODE_PULSE_PRIMARY};

    pwm_channel_bank #(
        .CHANNELS(`PWM_CHANNELS),
        .PERIOD(PERIOD)
    ) u_bank (
        .clk_i(CORE_CLK_I),
        .rst_n_i(rst_n),
        .cnt_i(st_q.cnt),
        .thr_i(st_q.thr),
        .enable_i(pwm_en),
        .pwm_o(pwm)
    );

    // A fractional accumulator makes the 16 MHz master tick from the core clock.
    assign acc_sum = {1'b0, st_q.acc} + {1'b0, TICK_STEP};
    assign wrap = st_q.tick && st_q.cnt == P15 - 15'd1;
    assign restart = sync_evt && st_q.sync_en && sync_present;
    assign wb_req = WB_CYC_I && WB_STB_I && !st_q.ack;

    // Duty threshold; a full code means always on, and values that would make
    // two staggered channels switch together are nudged by one master tick.
    assign prod = 27'(st_q.level) * 27'(PERIOD);
    assign thr_raw = (st_q.level == 12'hFFF) ? P15 : prod[26:12];
    always_comb begin
        thr_fix = thr_raw;
        if (thr_raw == 15'(OFS) || thr_raw == 15'(2 * OFS) ||
            thr_raw == 15'(PERIOD - OFS) || thr_raw == 15'(PERIOD - 2 * OFS)) begin
            thr_fix = thr_raw + 15'd1;
        end
    end

    // All block state advances here.
    always_comb begin
        st_d = st_q;
        st_d.ack = wb_req;
        st_d.rst_req = long_press;
        // The strap is caught once, on the first cycle after reset release.
        if (!st_q.strap_done) begin
            st_d.strap_done = 1'b1;
            st_d.mode = MODE_STRAP_I ? dim_pwm_pkg::MODE_PULSE_PRIMARY
                                     : dim_pwm_pkg::MODE_ANALOG_PRIMARY;
        end
        // Master time base.
        st_d.tick = acc_sum >= {1'b0, TICK_DEN};
        st_d.acc = st_d.tick ? 8'(acc_sum - {1'b0, TICK_DEN}) : acc_sum[7:0];
        // Period counter; a sync event pulls it back to the start.
        if (restart) begin
            st_d.cnt = '0;
        end else if (wrap) begin
            st_d.cnt = '0;
        end else if (st_q.tick) begin
            st_d.cnt = st_q.cnt + 15'd1;
        end
        // The code is widened to 12 bits so that zero and full scale map exactly.
        if (st_q.src_net) begin
            st_d.level = {st_q.net_level, st_q.net_level[9:8]};
        end else begin
            st_d.level = {DIMMER_LEVEL_INPUT_I, DIMMER_LEVEL_INPUT_I[9:8]};
        end
        // Duty only changes at the primary's period boundary, so no primary pulse is cut short.
        if (wrap || restart) begin
            st_d.thr = thr_fix;
        end
        st_d.analog = (st_q.mode == dim_pwm_pkg::MODE_ANALOG_PRIMARY) ? st_q.level
                                                                     : 12'h000;
        // Register writes take effect with the acknowledge.
        st_d.rdata = 32'h0000_0000;
        if (wb_req && WB_WE_I) begin
            if (WB_ADR_I == `ADDR_CTRL && WB_SEL_I[0]) begin
                st_d.src_net = WB_DAT_I[`CTRL_SRC_NET_BIT];
                st_d.sync_en = WB_DAT_I[`CTRL_SYNC_EN_BIT];
            end
            if (WB_ADR_I == `ADDR_NET_LEVEL) begin
                if (WB_SEL_I[0]) begin
                    st_d.net_level[7:0] = WB_DAT_I[7:0];
                end
                if (WB_SEL_I[1]) begin
                    st_d.net_level[9:8] = WB_DAT_I[9:8];
                end
            end
        end else if (wb_req) begin
            unique case (WB_ADR_I)
                `ADDR_CTRL: begin
                    st_d.rdata[`CTRL_SRC_NET_BIT] = st_q.src_net;
                    st_d.rdata[`CTRL_SYNC_EN_BIT] = st_q.sync_en;
                end
                `ADDR_NET_LEVEL: begin
                    st_d.rdata[9:0] = st_q.net_level;
                end
                `ADDR_STATUS: begin
                    st_d.rdata[`STAT_MODE_BIT] = st_q.mode == dim_pwm_pkg::MODE_PULSE_PRIMARY;
                    st_d.rdata[`STAT_SYNC_PRESENT_BIT] = sync_present;
                    st_d.rdata[`STAT_SYNC_ACTIVE_BIT] = sync_present && st_q.sync_en;
                    st_d.rdata[`STAT_LONG_PRESS_BIT] = long_press;
                    st_d.rdata[`STAT_LEVEL_LSB +: 12] = st_q.level;
                end
                default: begin
                    st_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        // A long press puts the control registers, level, period count and threshold back to their reset values; the strapped mode is kept.
        if (long_press) begin
            st_d.src_net = `CTRL_SRC_NET_RESET;
            st_d.sync_en = `CTRL_SYNC_EN_RESET;
            st_d.net_level = `NET_LEVEL_RESET;
            st_d.cnt = '0;
            st_d.thr = '0;
            st_d.level = '0;
        end
    end

    // State register.
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{sync_en: `CTRL_SYNC_EN_RESET, mode: dim_pwm_pkg::MODE_ANALOG_PRIMARY,
                      default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // Every top output comes from a flop here or in the comparator bank.
    assign WB_ACK_O = st_q.ack;
    assign WB_DAT_O = st_q.rdata;
    assign PRIMARY_ANALOG_OR_PULSE_PIN_O = pwm[0];
    assign SECOND_OUTPUT_ALIAS_O = pwm[1];
    assign THIRD_OUTPUT_ALIAS_O = pwm[2];
    assign PRIMARY_ANALOG_LEVEL_O = st_q.analog;
    assign LONG_PRESS_RESET_O = st_q.rst_req;

    // Helper for the edge check: cycles since the count or threshold jumped.
    logic [1:0] calm_q;
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            calm_q <= 2'd0;
        end else if (restart || long_press || st_d.thr != st_q.thr) begin
            calm_q <= 2'd0;
        end else if (calm_q != 2'd3) begin
            calm_q <= calm_q + 2'd1;
        end
    end

    chk_tick_rate: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        st_q.tick |=> !st_q.tick [*5] ##[1:2] st_q.tick)
        else $error("Master tick is not 16 MHz on average.");
    chk_analog_mode: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (st_q.strap_done && st_q.mode == dim_pwm_pkg::MODE_ANALOG_PRIMARY) [*2]
        |-> !PRIMARY_ANALOG_OR_PULSE_PIN_O)
        else $error("Primary pin pulses in analog mode.");
    chk_period_wrap: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (st_q.cnt < P15) and (wrap && !long_press |=> st_q.cnt == 15'd0))
        else $error("Period counter left its range.");
    chk_stagger: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        calm_q >= 2'd2 |-> $countones(pwm ^ $past(pwm)) <= 1)
        else $error("Two channels switched together.");
    chk_full_range: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        st_q.thr == P15 && pwm_en[0] ##1 st_q.thr == P15 |-> PRIMARY_ANALOG_OR_PULSE_PIN_O)
        else $error("Full level does not hold the primary high.");
    chk_zero_tracks: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        st_q.thr == 15'd0 ##1 st_q.thr == 15'd0 |-> pwm == 3'b000)
        else $error("Outputs active at zero level.");
    chk_dimmer_src: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        !st_q.src_net && !long_press |=>
        st_q.level[11:2] == $past(DIMMER_LEVEL_INPUT_I))
        else $error("Level does not follow the dimmer code.");
    chk_analog_level: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        st_q.mode == dim_pwm_pkg::MODE_ANALOG_PRIMARY |=>
        PRIMARY_ANALOG_LEVEL_O == $past(st_q.level))
        else $error("Analog level does not follow the dimming level.");
    chk_sync_restart: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        restart |=> st_q.cnt == 15'd0 ##1 st_q.cnt <= 15'd1)
        else $error("Sync event did not restart the period.");
    // Without a live sync source the count may only hold or step by one tick.
    chk_free_run: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        !sync_present && !wrap && !long_press |=>
        15'(st_q.cnt - $past(st_q.cnt)) <= 15'd1)
        else $error("Period count jumped without a sync source.");
    chk_long_reset: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        long_press |=> LONG_PRESS_RESET_O && !st_q.src_net && st_q.sync_en)
        else $error("Long press did not reset the block.");
endmodule

// ==== shared/dim_pwm_consts.svh ====
// Constants for the daylight dimming PWM output stage.
`ifndef DIM_PWM_CONSTS_SVH
`define DIM_PWM_CONSTS_SVH
`define CORE_CLK_HZ 100000000
`define MASTER_CLK_HZ 16000000
`define PWM_FREQ_HZ 888
`define PWM_BITS 12
`define DIM_CODE_BITS 10
`define PWM_CHANNELS 3
`define LONG_PRESS_MS 100
`define SYNC_LOSS_MS 50
`define ADDR_CTRL 8'h00
`define ADDR_NET_LEVEL 8'h04
`define ADDR_STATUS 8'h08
`define CTRL_SRC_NET_BIT 0
`define CTRL_SYNC_EN_BIT 1
`define CTRL_SRC_NET_RESET 1'h0
`define CTRL_SYNC_EN_RESET 1'h1
`define NET_LEVEL_RESET 10'h000
`define STAT_MODE_BIT 0
`define STAT_SYNC_PRESENT_BIT 1
`define STAT_SYNC_ACTIVE_BIT 2
`define STAT_LONG_PRESS_BIT 3
`define STAT_LEVEL_LSB 16
`endif

// ==== shared/dim_pwm_pkg.sv ====
// Types shared by the dimming output stage.
package dim_pwm_pkg;
    typedef enum logic {
        MODE_ANALOG_PRIMARY,
        MODE_PULSE_PRIMARY
    } out_mode_e;
    typedef logic [14:0] period_cnt_t;
    typedef logic [11:0] duty_t;
endpackage

// ==== hw/pwm_channel_bank.sv ====
// Staggered comparators that turn one period count into several PWM outputs.
`timescale 1ns/10ps
module pwm_channel_bank #(
    parameter int CHANNELS = 3,
    parameter int PERIOD = 18018
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Shared period count and duty threshold.
    input wire dim_pwm_pkg::period_cnt_t cnt_i,
    input wire dim_pwm_pkg::period_cnt_t thr_i,
    input wire logic [CHANNELS-1:0] enable_i,
    // Registered pulse outputs.
    output logic [CHANNELS-1:0] pwm_o
);
    typedef struct packed {
        logic [CHANNELS-1:0] pwm;
    } bank_s;
    localparam int OFS = PERIOD / CHANNELS;
    bank_s st_q;
    bank_s st_d;
    logic [CHANNELS-1:0] hi;

    // Each channel sees the count shifted by its own phase, so edges are spread.
    for (genvar k = 0; k < CHANNELS; k++) begin : g_ch
        logic [15:0] sum;
        logic [15:0] phase;
        assign sum = {1'b0, cnt_i} + 16'(k * OFS);
        assign phase = (sum >= 16'(PERIOD)) ? sum - 16'(PERIOD) : sum;
        assign hi[k] = enable_i[k] && (phase < {1'b0, thr_i});
    end

    // Next state is simply the comparator results.
    always_comb begin
        st_d = st_q;
        st_d.pwm = hi;
    end

    // Outputs come straight from these flops.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pwm_o = st_q.pwm;
endmodule

// ==== hw/sync_reset_monitor.sv ====
// Watches the shared sync and reset pin: sync events, presence and long press.
`timescale 1ns/10ps
module sync_reset_monitor #(
    parameter int LONG_CYCLES = 10000000,
    parameter int LOSS_CYCLES = 5000000
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pin level, already synchronous.
    input wire logic pin_i,
    // Results.
    output logic sync_evt_o,
    output logic present_o,
    output logic long_press_o
);
    typedef struct packed {
        logic prev;
        logic [23:0] low_cnt;
        logic long_press;
        logic [23:0] quiet;
        logic present;
        logic evt;
    } mon_s;
    mon_s st_q;
    mon_s st_d;

    // A low level is counted; only its release, short of a long press, is a sync.
    always_comb begin
        st_d = st_q;
        st_d.prev = pin_i;
        st_d.evt = 1'b0;
        if (!pin_i) begin
            if (st_q.low_cnt != 24'(LONG_CYCLES)) begin
                st_d.low_cnt = st_q.low_cnt + 24'd1;
            end
            if (st_q.low_cnt == 24'(LONG_CYCLES - 1)) begin
                st_d.long_press = 1'b1;
            end
        end else begin
            st_d.low_cnt = '0;
            st_d.long_press = 1'b0;
            if (!st_q.prev && !st_q.long_press) begin
                st_d.evt = 1'b1;
                st_d.present = 1'b1;
                st_d.quiet = '0;
            end
        end
        // An open pin never releases, so presence times out by itself.
        if (!st_d.evt) begin
            if (st_q.quiet != 24'(LOSS_CYCLES)) begin
                st_d.quiet = st_q.quiet + 24'd1;
            end
            if (st_q.quiet == 24'(LOSS_CYCLES - 1)) begin
                st_d.present = 1'b0;
            end
        end
    end

    // The idle pin level is high.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '{prev: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_evt_o = st_q.evt;
    assign present_o = st_q.present;
    assign long_press_o = st_q.long_press;

    chk_long_press_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !pin_i && st_q.low_cnt == 24'(LONG_CYCLES - 1) |=> st_q.long_press)
        else $error("Long press not flagged at threshold.");
    chk_long_no_sync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pin_i && !st_q.prev && st_q.long_press |=> !st_q.evt)
        else $error("Sync event after a long press.");
    chk_low_no_sync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !pin_i ##1 !pin_i |-> !st_q.evt)
        else $error("Sync event while pin stays low.");
endmodule

// ==== tb/dim_load_model.sv ====
// Load model: three dimming drivers that integrate the pulse outputs.
`timescale 1ns/10ps
module dim_load_model (
    // Clock and measurement window.
    input wire logic clk_i,
    input wire logic clear_i,
    // Pulse outputs of the stage, channel 0 is the primary.
    input wire logic [2:0] pwm_i,
    // Measured on time, edge count and coincident switching.
    output logic [2:0][15:0] hi_cnt_o,
    output logic [2:0][7:0] rise_cnt_o,
    output logic [15:0] clash_cnt_o
);
    logic [2:0] last_q;

    // A driver only sees average on time; two channels switching on one edge is an EMI clash.
    always_ff @(posedge clk_i) begin
        last_q <= pwm_i;
        for (int k = 0; k < 3; k++) begin
            if (clear_i) begin
                hi_cnt_o[k] <= 16'h0000;
                rise_cnt_o[k] <= 8'h00;
            end else begin
                hi_cnt_o[k] <= hi_cnt_o[k] + 16'(pwm_i[k]);
                rise_cnt_o[k] <= rise_cnt_o[k] + 8'(pwm_i[k] & ~last_q[k]);
            end
        end
        if (clear_i) begin
            clash_cnt_o <= 16'h0000;
        end else if ($countones(pwm_i ^ last_q) > 1) begin
            clash_cnt_o <= clash_cnt_o + 16'h0001;
        end
    end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the dimming output stage.
`timescale 1ns/10ps
`include "dim_pwm_consts.svh"
module tb;
    localparam int P = 300;
    localparam int LONG = 200;
    localparam int LOSS = 4000;
    localparam int WIN = 4 * P * 100 / 16;
    logic clk;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [9:0] dim = 10'h000;
    logic strap = 1'b1;
    logic sync_pin = 1'b1;
    logic clr = 1'b0;
    logic ack, pri, sec, thd, lpr;
    logic [31:0] dat_o, q;
    logic [11:0] alvl;
    logic [2:0][15:0] hi;
    logic [2:0][7:0] rise;
    logic [15:0] clash;
    int n_errors = 0;
    int cmp_count = 0;

    daylight_dimming_pwm_outputs #(.PERIOD(P), .LONG_CYCLES(LONG), .LOSS_CYCLES(LOSS)) dut (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_ACK_O(ack), .WB_DAT_O(dat_o),
        .DIMMER_LEVEL_INPUT_I(dim), .MODE_STRAP_I(strap), .SYNC_OR_RESET_PIN_I(sync_pin),
        .PRIMARY_ANALOG_OR_PULSE_PIN_O(pri), .PRIMARY_ANALOG_LEVEL_O(alvl),
        .SECOND_OUTPUT_ALIAS_O(sec), .THIRD_OUTPUT_ALIAS_O(thd), .LONG_PRESS_RESET_O(lpr));

    dim_load_model load (.clk_i(clk), .clear_i(clr), .pwm_i({thd, sec, pri}),
        .hi_cnt_o(hi), .rise_cnt_o(rise), .clash_cnt_o(clash));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string s);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    // Averages are judged with a tolerance because tick edges jitter by one core cycle.
    task automatic cmp_near(input logic [31:0] got, input int exp, input int tol, input string s);
        cmp_count++;
        // Signed compare, so a window that reaches below zero still works.
        if (($signed({1'b0, got}) >= exp - tol && $signed({1'b0, got}) <= exp + tol) !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s got %0d exp %0d", $time, s, got, exp);
        end
    endtask

    // One classic cycle; values read just after an edge are those that the edge sampled.
    task automatic wb_go(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            cmp_val(1'b0, 1'b1, "bus answer");
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string s);
        wb_go(1'b0, a, 32'h0000_0000);
        cmp_val(q, e, s);
    endtask

    task automatic do_reset(input logic m);
        @(posedge clk);
        rst_n <= 1'b0;
        strap <= m;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic measure;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (WIN) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic pulse;
        @(posedge clk);
        sync_pin <= 1'b0;
        repeat (5) @(posedge clk);
        sync_pin <= 1'b1;
    endtask

    // Expected threshold in ticks; full code means always on.
    function automatic int exp_thr(input logic [9:0] c);
        logic [11:0] l;
        l = {c, c[9:8]};
        if (c == 10'h3ff) return P;
        return (int'(l) * P) >> 12;
    endfunction

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog sized well above the expected run of about 54k cycles.
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        close_out();
    end

    initial begin
        logic [9:0] codes [3];
        int n;
        codes = '{10'h000, 10'h200, 10'h3ff};
        do_reset(1'b1);
        chk_rd(`ADDR_CTRL, 32'h0000_0002, "ctrl reset");
        chk_rd(`ADDR_NET_LEVEL, 32'h0000_0000, "net level reset");
        wb_go(1'b1, 8'h0c, 32'hffff_ffff);
        chk_rd(8'h0c, 32'h0000_0000, "unmapped read");
        wb_go(1'b1, `ADDR_STATUS, 32'hffff_ffff);
        chk_rd(`ADDR_STATUS, 32'h0000_0001, "status after reset");
        foreach (codes[i]) begin
            dim <= codes[i];
            repeat (2000) @(posedge clk);
            measure();
            for (int k = 0; k < 3; k++) begin
                cmp_near(hi[k], exp_thr(codes[i]) * 25, 30, "on time");
            end
            cmp_val(clash, 32'h0000_0000, "coincident edges");
            if (i == 1) begin
                cmp_near(rise[2], 4, 1, "periods in window");
            end
            chk_rd(`ADDR_STATUS, {4'h0, codes[i], codes[i][9:8], 16'h0001}, "level");
        end
        wb_go(1'b1, `ADDR_NET_LEVEL, 32'h0000_00c0);
        wb_go(1'b1, `ADDR_CTRL, 32'h0000_0003);
        repeat (2000) @(posedge clk);
        measure();
        cmp_near(hi[0], exp_thr(10'h0c0) * 25, 30, "network level");
        pulse();
        repeat (100) @(posedge clk);
        n = 0;
        while (pri !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        while (pri !== 1'b0 && n < 8000) begin
            @(negedge clk);
            n++;
        end
        repeat (200) @(posedge clk);
        pulse();
        repeat (20) @(negedge clk);
        cmp_val(pri, 1'b1, "sync restart");
        cmp_val(lpr, 1'b0, "short low");
        wb_go(1'b0, `ADDR_STATUS, 32'h0000_0000);
        cmp_val(q[2:1], 2'b11, "sync seen");
        wb_go(1'b1, `ADDR_CTRL, 32'h0000_0001);
        chk_rd(`ADDR_STATUS, {4'h0, 12'h300, 16'h0003}, "sync disabled");
        repeat (LOSS + 500) @(posedge clk);
        chk_rd(`ADDR_STATUS, {4'h0, 12'h300, 16'h0001}, "open sync pin");
        wb_go(1'b1, `ADDR_CTRL, 32'h0000_0003);
        @(posedge clk);
        sync_pin <= 1'b0;
        repeat (LONG + 20) @(posedge clk);
        @(negedge clk);
        cmp_val(lpr, 1'b1, "long press");
        @(posedge clk);
        sync_pin <= 1'b1;
        repeat (5) @(negedge clk);
        cmp_val(lpr, 1'b0, "long press end");
        chk_rd(`ADDR_CTRL, 32'h0000_0002, "ctrl reinit");
        chk_rd(`ADDR_NET_LEVEL, 32'h0000_0000, "net reinit");
        dim <= 10'h155;
        do_reset(1'b0);
        repeat (2000) @(posedge clk);
        @(negedge clk);
        cmp_val(alvl, 12'h555, "analog level");
        measure();
        cmp_near(hi[0], 0, 0, "primary pulse idle");
        cmp_near(hi[1], exp_thr(10'h155) * 25, 30, "second follows");
        chk_rd(`ADDR_STATUS, {4'h0, 12'h555, 16'h0000}, "mode 0");
        close_out();
    end
endmodule
